//--- inc/slp_pkg.sv
// constants, types and register map for the select-protocol port
package slp_pkg;
    localparam int ADDR_BITS = 10;
    localparam int POS_BITS = 3;
    localparam int CFG_BITS = 3;
    localparam int GRP_BITS = POS_BITS + CFG_BITS;
    localparam int PATHS = 3;
    localparam int BYP_BITS = 5;
    localparam int CNT_W = 5;
    localparam int GRP_W = 3;
    localparam int ACK_PAIRS = 1 + ADDR_BITS + 2 + GRP_BITS + 1 + 1;
    localparam int ACK_LEN = 2 * ACK_PAIRS;
    localparam int TX_W = 6;

    localparam logic [ADDR_BITS-1:0] GLOBAL_RESET_CODE = 10'h000;
    localparam logic [ADDR_BITS-1:0] GLOBAL_DISCONNECT_CODE = 10'h3fe;
    localparam logic [ADDR_BITS-1:0] GLOBAL_SYNC_CODE = 10'h3ff;
    localparam logic [CNT_W-1:0] ADDR_LEN = 5'h0a;
    localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
    localparam logic [GRP_W-1:0] GRP_LAST = 3'h5;
    localparam logic [TX_W-1:0] TX_LEN = 6'h2a;

    // wishbone word offsets (byte addresses)
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_LAST = 4'h8;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam int CTRL_RX_EN = 0;
    localparam int CTRL_BYP_IGNORE = 1;
    localparam int ST_TAP_LSB = 0;
    localparam int ST_RES_LSB = 4;
    localparam int ST_CONN = 8;
    localparam int ST_MCAST = 9;
    localparam int ST_TX = 10;
    localparam int LAST_POS_LSB = 10;
    localparam int LAST_CFG_LSB = 13;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR, TAP_PAUSE_DR,
        TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SHIFT_IR, TAP_EXIT1_IR,
        TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } slp_tap_e;

    typedef enum logic [2:0] {
        RES_NONE, RES_MATCH, RES_NO_MATCH, RES_DISCONNECT, RES_RESET, RES_SYNC, RES_SOFT, RES_HARD
    } slp_result_e;

    typedef enum logic [2:0] {
        RX_WAIT, RX_IDLE, RX_ADDR, RX_GAP, RX_CMD, RX_END, RX_SKIP
    } slp_rx_e;
endpackage

//--- hdl/slp_select_port.sv
// select-protocol receiver, acknowledge transmitter, tap monitor and connect control
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module slp_select_port
    import slp_pkg::*;
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic primary_test_clock,
    input wire logic primary_test_reset_n,
    input wire logic primary_mode_select,
    input wire logic primary_serial_in,
    output logic primary_serial_out,
    output logic primary_serial_out_oe_n,
    input wire logic secondary_return_in,
    output logic secondary_serial_out,
    output logic secondary_mode_select,
    output logic [PATHS-1:0] secondary_path_en,
    output logic [PATHS-1:0] connect_indicator_n,
    input wire logic [BYP_BITS-1:0] protocol_bypass_n,
    input wire logic [ADDR_BITS-1:0] strap_address,
    input wire logic [POS_BITS-1:0] strap_position
);
    localparam int NSYNC = 5;
    localparam int I_TCK = 0;
    localparam int I_TRST = 1;
    localparam int I_TMS = 2;
    localparam int I_TDI = 3;
    localparam int I_RET = 4;

    // three-stage capture, level accepted when stages two and three agree
    logic [NSYNC-1:0] sync1_reg, sync2_reg, sync3_reg, filt_reg;
    logic tck_prev_reg;
    logic tck_rise, tck_fall, tms, tdi, trst_n;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sync1_reg <= '1;
            sync2_reg <= '1;
            sync3_reg <= '1;
            filt_reg <= '1;
            tck_prev_reg <= 1'b1;
        end else begin
            sync1_reg <= {secondary_return_in, primary_serial_in, primary_mode_select,
                          primary_test_reset_n, primary_test_clock};
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            filt_reg <= (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));
            tck_prev_reg <= filt_reg[I_TCK];
        end
    end

    assign tck_rise = filt_reg[I_TCK] & ~tck_prev_reg;
    assign tck_fall = ~filt_reg[I_TCK] & tck_prev_reg;
    assign tms = filt_reg[I_TMS];
    assign tdi = filt_reg[I_TDI];
    assign trst_n = filt_reg[I_TRST];

    function automatic slp_tap_e tap_step(input slp_tap_e s, input logic m);
        case (s)
            TAP_RESET: tap_step = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tap_step = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tap_step = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tap_step = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tap_step = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tap_step = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tap_step = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tap_step = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tap_step = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tap_step = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tap_step = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tap_step = m ? TAP_SEL_DR : TAP_IDLE;
            default: tap_step = TAP_RESET;
        endcase
    endfunction

    function automatic logic is_pause(input slp_tap_e s);
        is_pause = (s == TAP_PAUSE_DR) || (s == TAP_PAUSE_IR);
    endfunction

    // tap state monitor
    slp_tap_e tap_reg, tap_next;
    logic tap_change;
    assign tap_next = tap_step(tap_reg, tms);
    assign tap_change = tck_rise && (tap_next != tap_reg);

    always_ff @(posedge clock) begin
        if (!rst_n || !trst_n) begin
            tap_reg <= TAP_RESET;
        end else if (tck_rise) begin
            tap_reg <= tap_next;
        end
    end

    logic [1:0] ctrl_reg;
    logic rx_allowed;
    assign rx_allowed = ctrl_reg[CTRL_RX_EN] && ((tap_reg == TAP_RESET) || (tap_reg == TAP_IDLE)
                        || is_pause(tap_reg));

    // select protocol receiver
    slp_rx_e rx_reg;
    logic phase_reg, first_reg, hi_reg;
    logic [ADDR_BITS-1:0] addr_reg;
    logic [CNT_W-1:0] acnt_reg;
    logic all1_reg, all0_reg;
    logic [GRP_BITS-1:0] grp_reg;
    logic [GRP_W-1:0] gcnt_reg;
    logic [CNT_W-1:0] ccnt_reg;
    logic found_reg;
    logic [POS_BITS-1:0] pos_reg;
    logic [CFG_BITS-1:0] cfg_reg;
    logic done_reg, soft_reg, hard_reg;
    logic [GRP_BITS-1:0] grp_full;
    logic sym_valid, sym_sel, sym_idle, sym_data, sym_bit, in_msg;

    assign sym_valid = tck_rise && phase_reg;
    assign sym_sel = !first_reg && !tdi;
    assign sym_idle = first_reg && tdi;
    assign sym_data = first_reg != tdi;
    assign sym_bit = tdi;
    assign grp_full = {sym_bit, grp_reg[GRP_BITS-1:1]};
    assign in_msg = (rx_reg == RX_ADDR) || (rx_reg == RX_GAP) || (rx_reg == RX_CMD) || (rx_reg == RX_END);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rx_reg <= RX_WAIT;
            phase_reg <= 1'b0;
            first_reg <= 1'b1;
            hi_reg <= 1'b0;
            addr_reg <= '0;
            acnt_reg <= '0;
            all1_reg <= 1'b1;
            all0_reg <= 1'b1;
            grp_reg <= '0;
            gcnt_reg <= '0;
            ccnt_reg <= '0;
            found_reg <= 1'b0;
            pos_reg <= '0;
            cfg_reg <= '0;
            done_reg <= 1'b0;
            soft_reg <= 1'b0;
            hard_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            soft_reg <= 1'b0;
            hard_reg <= 1'b0;
            if (!rx_allowed || tap_change || !trst_n) begin
                // state change aborts; after data it is hard
                if ((rx_reg == RX_ADDR && acnt_reg != '0) || rx_reg == RX_GAP || rx_reg == RX_CMD
                    || rx_reg == RX_END) begin
                    hard_reg <= 1'b1;
                end
                rx_reg <= RX_WAIT;
                phase_reg <= 1'b0;
                hi_reg <= 1'b0;
            end else if (tck_rise) begin
                if (!in_msg && !phase_reg && tdi) begin
                    // highs between messages: idle, pairs begin at a low
                    hi_reg <= 1'b1;
                    if (hi_reg && rx_reg != RX_IDLE) begin
                        rx_reg <= RX_IDLE;
                    end
                end else if (!phase_reg) begin
                    first_reg <= tdi;
                    phase_reg <= 1'b1;
                end else begin
                    phase_reg <= 1'b0;
                    hi_reg <= 1'b0;
                    case (rx_reg)
                        RX_WAIT: rx_reg <= RX_WAIT;
                        RX_IDLE: begin
                            if (sym_sel) begin
                                rx_reg <= RX_ADDR;
                                acnt_reg <= '0;
                                all1_reg <= 1'b1;
                                all0_reg <= 1'b1;
                                gcnt_reg <= '0;
                                ccnt_reg <= '0;
                                found_reg <= 1'b0;
                            end else begin
                                soft_reg <= 1'b1;
                                rx_reg <= RX_SKIP;
                            end
                        end
                        RX_ADDR: begin
                            if (sym_data) begin
                                addr_reg <= {sym_bit, addr_reg[ADDR_BITS-1:1]};
                                acnt_reg <= (acnt_reg == CNT_MAX) ? CNT_MAX : acnt_reg + 1'b1;
                                all1_reg <= all1_reg & sym_bit;
                                all0_reg <= all0_reg & ~sym_bit;
                            end else if (acnt_reg == '0) begin
                                soft_reg <= 1'b1;
                                rx_reg <= RX_SKIP;
                            end else if (sym_idle || acnt_reg < ADDR_LEN) begin
                                hard_reg <= 1'b1;
                                rx_reg <= RX_SKIP;
                            end else if (acnt_reg > ADDR_LEN && !all1_reg && !all0_reg) begin
                                hard_reg <= 1'b1;
                                rx_reg <= RX_SKIP;
                            end else begin
                                rx_reg <= RX_GAP;
                            end
                        end
                        RX_GAP: begin
                            if (sym_sel) begin
                                rx_reg <= RX_CMD;
                            end else begin
                                hard_reg <= 1'b1;
                                rx_reg <= RX_SKIP;
                            end
                        end
                        RX_CMD: begin
                            if (sym_data) begin
                                grp_reg <= grp_full;
                                ccnt_reg <= (ccnt_reg == CNT_MAX) ? CNT_MAX : ccnt_reg + 1'b1;
                                if (gcnt_reg == GRP_LAST) begin
                                    gcnt_reg <= '0;
                                    // cascaded groups: keep the one for our position
                                    if (!found_reg && grp_full[POS_BITS-1:0] == strap_position) begin
                                        found_reg <= 1'b1;
                                        pos_reg <= grp_full[POS_BITS-1:0];
                                        cfg_reg <= grp_full[GRP_BITS-1:POS_BITS];
                                    end else if (!found_reg) begin
                                        pos_reg <= grp_full[POS_BITS-1:0];
                                    end
                                end else begin
                                    gcnt_reg <= gcnt_reg + 1'b1;
                                end
                            end else if (sym_sel && gcnt_reg == '0) begin
                                rx_reg <= RX_END;
                            end else begin
                                hard_reg <= 1'b1;
                                rx_reg <= RX_SKIP;
                            end
                        end
                        RX_END: begin
                            if (sym_idle) begin
                                done_reg <= 1'b1;
                                rx_reg <= RX_IDLE;
                            end else begin
                                hard_reg <= 1'b1;
                                rx_reg <= RX_SKIP;
                            end
                        end
                        RX_SKIP: rx_reg <= RX_SKIP;
                        default: rx_reg <= RX_WAIT;
                    endcase
                end
            end
        end
    end

    // acknowledge frame, index 0 leaves first
    function automatic logic [ACK_LEN-1:0] ack_frame(input logic [ADDR_BITS-1:0] a,
                                                     input logic [GRP_BITS-1:0] g);
        logic [ACK_LEN-1:0] f;
        int k;
        f = '0;
        k = 2;
        for (int i = 0; i < ADDR_BITS; i++) begin
            f[k] = ~a[i];
            f[k+1] = a[i];
            k = k + 2;
        end
        k = k + 4;
        for (int i = 0; i < GRP_BITS; i++) begin
            f[k] = ~g[i];
            f[k+1] = g[i];
            k = k + 2;
        end
        f[ACK_LEN-1] = 1'b1;
        f[ACK_LEN-2] = 1'b1;
        ack_frame = f;
    endfunction

    // connect control
    slp_result_e result_reg;
    logic conn_reg, mcast_reg, tx_start_reg, tx_done_reg, tx_busy_reg, tx_live_reg;
    logic [CFG_BITS-1:0] link_cfg_reg;
    logic [ADDR_BITS-1:0] last_addr_reg;
    logic [POS_BITS-1:0] last_pos_reg;
    logic [CFG_BITS-1:0] last_cfg_reg;
    logic [ACK_LEN-1:0] tx_sh_reg;
    logic [TX_W-1:0] tx_cnt_reg;
    logic [CFG_BITS-1:0] pend_cfg_reg;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            result_reg <= RES_NONE;
            conn_reg <= 1'b0;
            mcast_reg <= 1'b0;
            tx_start_reg <= 1'b0;
            link_cfg_reg <= '0;
            pend_cfg_reg <= '0;
            last_addr_reg <= '0;
            last_pos_reg <= '0;
            last_cfg_reg <= '0;
        end else begin
            tx_start_reg <= 1'b0;
            if (done_reg) begin
                result_reg <= RES_NO_MATCH;
                conn_reg <= 1'b0;
                mcast_reg <= 1'b0;
                last_addr_reg <= addr_reg;
                last_pos_reg <= pos_reg;
                last_cfg_reg <= cfg_reg;
                if (acnt_reg >= ADDR_LEN && all0_reg) begin
                    result_reg <= RES_RESET;
                end else if (acnt_reg >= ADDR_LEN && all1_reg) begin
                    if (is_pause(tap_reg)) begin
                        result_reg <= RES_SYNC;
                        mcast_reg <= 1'b1;
                    end
                end else if (addr_reg == GLOBAL_DISCONNECT_CODE) begin
                    result_reg <= RES_DISCONNECT;
                end else if (addr_reg == strap_address && found_reg) begin
                    result_reg <= RES_MATCH;
                    pend_cfg_reg <= cfg_reg;
                    tx_start_reg <= 1'b1;
                end
                // otherwise no match: nothing sent
            end else if (hard_reg) begin
                result_reg <= RES_HARD;
                conn_reg <= 1'b0;
                mcast_reg <= 1'b0;
            end else if (soft_reg) begin
                result_reg <= RES_SOFT;
            end else if (tx_done_reg) begin
                conn_reg <= 1'b1;
                link_cfg_reg <= pend_cfg_reg;
            end
        end
    end

    // acknowledge transmitter, launched on test clock falling edges
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_sh_reg <= '1;
            tx_cnt_reg <= '0;
            tx_busy_reg <= 1'b0;
            tx_live_reg <= 1'b0;
            tx_done_reg <= 1'b0;
        end else begin
            tx_done_reg <= 1'b0;
            if (tx_start_reg) begin
                tx_sh_reg <= ack_frame(addr_reg, {cfg_reg, pos_reg});
                tx_cnt_reg <= TX_LEN;
                tx_busy_reg <= 1'b1;
                tx_live_reg <= 1'b0;
            end else if (tx_busy_reg && (done_reg || hard_reg)) begin
                tx_busy_reg <= 1'b0;
                tx_live_reg <= 1'b0;
                tx_cnt_reg <= '0;
            end else if (tx_busy_reg && tck_fall) begin
                if (tx_cnt_reg == '0) begin
                    tx_busy_reg <= 1'b0;
                    tx_live_reg <= 1'b0;
                    tx_done_reg <= 1'b1;
                end else begin
                    // first fall starts driving so every bit stands a full period
                    if (tx_live_reg) begin
                        tx_sh_reg <= {1'b1, tx_sh_reg[ACK_LEN-1:1]};
                    end
                    tx_live_reg <= 1'b1;
                    tx_cnt_reg <= tx_cnt_reg - 1'b1;
                end
            end
        end
    end

    // pin drivers
    logic byp_active, shifting, path_on;
    logic [PATHS-1:0] path_mask;
    assign byp_active = !ctrl_reg[CTRL_BYP_IGNORE] && !(&protocol_bypass_n);
    assign shifting = (tap_reg == TAP_SHIFT_DR) || (tap_reg == TAP_SHIFT_IR);
    assign path_mask = byp_active ? ~protocol_bypass_n[PATHS-1:0]
                     : (conn_reg || mcast_reg) ? link_cfg_reg : '0;
    assign path_on = |path_mask;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            primary_serial_out <= 1'b1;
            primary_serial_out_oe_n <= 1'b1;
            secondary_serial_out <= 1'b1;
            secondary_mode_select <= 1'b1;
            secondary_path_en <= '0;
            connect_indicator_n <= '1;
        end else begin
            secondary_path_en <= path_mask;
            connect_indicator_n <= ~path_mask;
            if (path_on) begin
                secondary_mode_select <= tms;
                secondary_serial_out <= tdi;
            end
            if (tx_live_reg) begin
                primary_serial_out <= tx_sh_reg[0];
                primary_serial_out_oe_n <= 1'b0;
            end else if ((conn_reg || byp_active) && path_on && shifting) begin
                primary_serial_out <= filt_reg[I_RET];
                primary_serial_out_oe_n <= 1'b0;
            end else begin
                primary_serial_out <= 1'b1;
                primary_serial_out_oe_n <= 1'b1;
            end
        end
    end

    // wishbone classic slave, one wait state
    logic wb_hit;
    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_hit;
            if (wb_hit) begin
                wb_dat_o <= '0;
                case (wb_adr_i)
                    REG_CTRL: begin
                        if (wb_we_i && wb_sel_i[0]) begin
                            ctrl_reg <= wb_dat_i[1:0];
                        end
                        wb_dat_o[1:0] <= ctrl_reg;
                    end
                    REG_STATUS: begin
                        wb_dat_o[ST_TAP_LSB +: 4] <= tap_reg;
                        wb_dat_o[ST_RES_LSB +: 3] <= result_reg;
                        wb_dat_o[ST_CONN] <= conn_reg;
                        wb_dat_o[ST_MCAST] <= mcast_reg;
                        wb_dat_o[ST_TX] <= tx_busy_reg;
                    end
                    REG_LAST: begin
                        wb_dat_o[ADDR_BITS-1:0] <= last_addr_reg;
                        wb_dat_o[LAST_POS_LSB +: POS_BITS] <= last_pos_reg;
                        wb_dat_o[LAST_CFG_LSB +: CFG_BITS] <= last_cfg_reg;
                    end
                    default: wb_dat_o <= '0;
                endcase
            end
        end
    end
endmodule

`default_nettype wire

//--- verification/slp_select_port_monitor.sv
// assertion checker for the select-protocol port
`timescale 1ns/1ps
`default_nettype none
module slp_select_port_monitor
    import slp_pkg::*;
(
    input wire logic clock, input wire logic rst_n, input wire logic wb_cyc_i, input wire logic wb_stb_i,
    input wire logic wb_ack_o, input wire logic primary_serial_in, input wire logic primary_serial_out,
    input wire logic primary_serial_out_oe_n, input wire logic [PATHS-1:0] secondary_path_en,
    input wire logic [PATHS-1:0] connect_indicator_n
);
    wire logic oe_n = primary_serial_out_oe_n;
    wire logic [2:0] con = connect_indicator_n;
    logic [7:0] quiet;
    // cycles since the serial output last drove
    always_ff @(posedge clock) quiet <= (!rst_n || !oe_n) ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_ans; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ans: assert property (p_ans) else $error("no ack");
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack held");
    property p_rst; $rose(rst_n) |-> oe_n && con == 3'h7 && secondary_path_en == 3'h0; endproperty
    a_rst: assert property (p_rst) else $error("bad reset state");
    property p_map; con == ~secondary_path_en; endproperty
    a_map: assert property (p_map) else $error("indicator mismatch");
    property p_first; $fell(oe_n) |-> !primary_serial_out && primary_serial_in; endproperty
    a_first: assert property (p_first) else $error("bad ack start");
    property p_hold; $fell(oe_n) |=> !oe_n [*8]; endproperty
    a_hold: assert property (p_hold) else $error("ack cut short");
    property p_off; $fell(oe_n) |-> con == 3'h7; endproperty
    a_off: assert property (p_off) else $error("not off before ack");
    property p_on; $past(con) == 3'h7 && con != 3'h7 |-> quiet < 8'h28; endproperty
    a_on: assert property (p_on) else $error("on without ack");
endmodule
`default_nettype wire

//--- verification/slp_scan_master_model.sv
// central scan bus master driving the test port pins
`timescale 1ns/1ps
`default_nettype none
module slp_scan_master_model (
    output logic primary_test_clock,
    output logic primary_mode_select,
    output logic primary_serial_in,
    input wire logic primary_serial_out,
    input wire logic primary_serial_out_oe_n
);
    logic [41:0] ack = '0;
    int n_ack = 0;
    initial {primary_test_clock, primary_mode_select, primary_serial_in} = 3'h3;
    // one test clock; clock rests low between calls, only driven data is counted and shifted in
    task automatic tc(input logic m, input logic d);
        primary_mode_select = m;
        primary_serial_in = d;
        #62 primary_test_clock = 1'h1;
        n_ack += (primary_serial_out_oe_n === 1'h0);
        if (primary_serial_out_oe_n === 1'h0) ack = {primary_serial_out, ack[41:0+1]};
        #63 primary_test_clock = 1'h0;
    endtask
    // mode select held at m for the whole message
    task automatic msg(input logic m, input logic [9:0] a, input int al, input logic [5:0] g, input int gl);
        n_ack = 0;
        repeat (4) tc(m, 1'h1);
        repeat (2) tc(m, 1'h0);
        for (int i = 0; i < al; i++) begin
            tc(m, !a[i % 10]);
            tc(m, a[i % 10]);
        end
        repeat (4) tc(m, 1'h0);
        for (int i = 0; i < gl; i++) begin
            tc(m, !g[i % 6]);
            tc(m, g[i % 6]);
        end
        repeat (2) tc(m, 1'h0);
        repeat (50) tc(m, 1'h1);
    endtask
endmodule
`default_nettype wire

//--- verification/slp_select_port_tb_top.sv
// testbench for the select-protocol port
`timescale 1ns/1ps
`default_nettype none
module slp_select_port_tb_top
    import slp_pkg::*;
;
    typedef struct {logic [9:0] a; int al; logic [5:0] g; int gl; logic [2:0] r; logic [2:0] c;} slp_row_s;
    slp_row_s rows [8] = '{'{10'h2a5, 10, 6'h28, 6, 3'h1, 3'h2}, '{10'h2a4, 10, 6'h28, 6, 3'h2, 3'h7},
        '{10'h2a5, 10, 6'h29, 6, 3'h2, 3'h7}, '{10'h3fe, 10, 6'h28, 6, 3'h3, 3'h7},
        '{10'h000, 12, 6'h28, 6, 3'h4, 3'h7}, '{10'h3ff, 10, 6'h28, 6, 3'h2, 3'h7},
        '{10'h2a5, 9, 6'h28, 6, 3'h7, 3'h7}, '{10'h2a5, 10, 6'h28, 5, 3'h7, 3'h7}};
    logic clock = '0, rst_n = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, wb_ack_o, primary_serial_out_oe_n;
    logic primary_test_reset_n = '1, secondary_return_in = '1, primary_serial_out, secondary_serial_out;
    logic secondary_mode_select;
    logic [3:0] wb_adr_i = '0, wb_sel_i = '1;
    logic [31:0] wb_dat_i = '0, wb_dat_o, q;
    logic [2:0] secondary_path_en, connect_indicator_n, strap_position = '0;
    logic [4:0] protocol_bypass_n = '1;
    logic [9:0] strap_address = 10'h2a5;
    wire logic primary_test_clock, primary_mode_select, primary_serial_in;
    int n_fail = 0, samples_checked = 0;
    always #5 clock = ~clock;
    slp_select_port u_dut (.*);
    slp_scan_master_model u_bm (.*);
    task automatic chk(input string nm, input logic [41:0] exp, input logic [41:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do @(posedge clock); while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask
    function automatic logic [41:0] ack_exp(input logic [9:0] a, input logic [5:0] g);
        logic [41:0] e;
        e = 42'h300_0000_0000;
        for (int i = 0; i < 10; i++) e[2 + 2 * i +: 2] = {a[i], !a[i]};
        for (int i = 0; i < 6; i++) e[26 + 2 * i +: 2] = {g[i], !g[i]};
        return e;
    endfunction
    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= '1;
        wb(1'h0, REG_STATUS, '0);
        chk("status", 42'h0, q[10:0]);
        wb(1'h1, REG_CTRL, 32'h3);
        wb(1'h0, REG_CTRL, '0);
        chk("ctrl", 42'h3, q);
        wb(1'h0, 4'hc, '0);
        chk("unmapped", 42'h0, q);
        foreach (rows[i]) begin
            u_bm.msg(1'h1, rows[i].a, rows[i].al, rows[i].g, rows[i].gl);
            wb(1'h0, REG_STATUS, '0);
            chk("result", rows[i].r, q[6:4]);
            chk("connect", rows[i].c, connect_indicator_n);
            chk("ack count", rows[i].r == 3'h1 ? 42 : 0, u_bm.n_ack);
            $display("row %0d done", i);
        end
        chk("ack bits", ack_exp(10'h2a5, 6'h28), u_bm.ack);
        u_bm.msg(1'h1, 10'h2a5, 10, 6'h28, 6);
        repeat (4) u_bm.tc(1'h1, 1'h1);
        u_bm.tc(1'h1, 1'h0);
        repeat (8) u_bm.tc(1'h1, 1'h1);
        wb(1'h0, REG_STATUS, '0);
        chk("soft", {3'h6, 3'h2}, {q[6:4], connect_indicator_n});
        wb(1'h1, REG_CTRL, 32'h1);
        protocol_bypass_n <= 5'h1b;
        repeat (2) @(posedge clock);
        chk("bypass", 3'h3, connect_indicator_n);
        protocol_bypass_n <= '1;
        repeat (4) u_bm.tc(1'h1, 1'h1);
        repeat (3) u_bm.tc(1'h1, 1'h0);
        repeat (8) u_bm.tc(1'h1, 1'h1);
        wb(1'h0, REG_STATUS, '0);
        chk("hard", {3'h7, 3'h7}, {q[6:4], connect_indicator_n});
        u_bm.tc(1'h0, 1'h1);
        u_bm.tc(1'h1, 1'h1);
        repeat (2) u_bm.tc(1'h0, 1'h1);
        u_bm.msg(1'h0, 10'h2a5, 10, 6'h28, 6);
        chk("shift ack", 42'h0, u_bm.n_ack);
        u_bm.tc(1'h1, 1'h1);
        u_bm.tc(1'h0, 1'h1);
        u_bm.msg(1'h0, 10'h2a5, 10, 6'h00, 6);
        chk("pause ack", 42, u_bm.n_ack);
        u_bm.msg(1'h0, 10'h3ff, 12, 6'h28, 6);
        wb(1'h0, REG_STATUS, '0);
        chk("pause sync", {4'h6, 3'h5}, {q[3:0], q[6:4]});
        $display("error and state tests done");
        results();
    end
    initial begin
        #900000;
        n_fail++;
        results();
    end
endmodule
bind slp_select_port slp_select_port_monitor u_mon (.*);
`default_nettype wire
